// >>> logic/ddc_capture_pkg.sv
// Purpose: shared constants for the four-bus sample capture front end
// Assumes: 17-bit sample buses, two global sync inputs, four response targets
// Notes: all field positions and select codes live here; reset values stay in the modules
package ddc_capture_pkg;
	// sample and bus geometry
	localparam int SampleWidth = 17;
	localparam int NumBuses = 4;
	localparam int BusA = 0;
	localparam int BusB = 1;
	localparam int BusC = 2;
	localparam int BusD = 3;
	// position of the bit-order reverse flag in indirect location zero
	localparam int BitReversePos = 4;
	localparam logic [15:0] IndirectLocZero = 16'h0000;
	// sync response targets: one enable bit per target per sync input
	localparam int NumTargets = 4;
	localparam int TgtNco = 0;
	localparam int TgtDecim = 1;
	localparam int TgtFilter = 2;
	localparam int TgtOutput = 3;
	// sync output source select
	localparam logic [1:0] SyncSrcSoft = 2'h0;
	localparam logic [1:0] SyncSrcIn1 = 2'h1;
	localparam logic [1:0] SyncSrcIn2 = 2'h2;
	// internal loopback target select
	localparam logic [1:0] LoopNone = 2'h0;
	localparam logic [1:0] LoopIn1 = 2'h1;
	localparam logic [1:0] LoopIn2 = 2'h2;
	// sync output pulse length in clk cycles
	localparam int SyncPulseCycles = 2;
	// capture fifo shape
	localparam int FifoDepth = 16;
	// capture state per bus
	typedef enum logic [2:0]
	{
		CapIdle = 3'h1,
		CapArmed = 3'h2,
		CapHalted = 3'h4
	} cap_state_e;
endpackage

// >>> logic/capture_fifo.sv
// Purpose: synchronous valid/ready fifo for captured samples
// Assumes: single clock, write and read in the same cycle allowed
// Notes: full and empty are exact; ready on the fill side is not full
`timescale 1ns/1ns
module capture_fifo
#(
	parameter int Width = 17,
	parameter int Depth = 16
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [Width-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [Width-1:0] outData
);
	localparam int Aw = $clog2(Depth);
	// elaboration check: pointer wrap needs a power-of-two depth
	if (Depth < 2 || (1 << Aw) != Depth)
	begin : g_bad_depth
		$error("capture_fifo depth must be a power of two, at least 2");
	end
	// storage array
	logic [Width-1:0] mem [Depth];
	logic [Aw:0] wrPtr_q;
	logic [Aw:0] rdPtr_q;
	wire isFull = (wrPtr_q[Aw] != rdPtr_q[Aw]) && (wrPtr_q[Aw-1:0] == rdPtr_q[Aw-1:0]);
	wire isEmpty = (wrPtr_q == rdPtr_q);
	wire doWrite = inValid && !isFull;
	wire doRead = outReady && !isEmpty;
	assign inReady = !isFull;
	assign outValid = !isEmpty;
	assign outData = mem[rdPtr_q[Aw-1:0]];
	// storage write, no reset needed on data
	always_ff @(posedge clk)
	begin
		if (doWrite)
			mem[wrPtr_q[Aw-1:0]] <= inData;
	end
	// pointers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end
		else
		begin
			if (doWrite)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (doRead)
				rdPtr_q <= rdPtr_q + 1'b1;
		end
	end
endmodule

// >>> logic/ddc_input_capture_sync.sv
// Purpose: sample capture, clock selection and sync control of a four-bus converter front end
// Assumes: clk is the processing clock; bus clocks, enables, data, syncs and reset_n are pins
// Notes: bus clocks are sampled as levels and their edges found on clk
`timescale 1ns/1ns
module ddc_input_capture_sync
	import ddc_capture_pkg::*;
#(
	parameter int Width = ddc_capture_pkg::SampleWidth,
	parameter int Depth = ddc_capture_pkg::FifoDepth
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// device reset pin, active low
	input wire logic resetPin_n,
	// sample bus pins
	input wire logic [ddc_capture_pkg::NumBuses*Width-1:0] busData,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] bus_enable_n,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] busClk,
	// capture configuration
	input wire logic [ddc_capture_pkg::NumBuses-1:0] edgeFalling,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] useMasterClk,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] interpMode,
	input wire logic [15:0] indirectWordAddr,
	input wire logic [15:0] indirectWordData,
	input wire logic indirectWrite,
	// sync inputs and configuration
	input wire logic global_sync_in_1,
	input wire logic global_sync_in_2,
	input wire logic [ddc_capture_pkg::NumTargets-1:0] syncRespEn1,
	input wire logic [ddc_capture_pkg::NumTargets-1:0] syncRespEn2,
	input wire logic [1:0] syncOutSrc,
	input wire logic softSync,
	input wire logic [1:0] loopSel,
	// sync actions and sync output
	output logic [ddc_capture_pkg::NumTargets-1:0] syncAction,
	output logic sync_output,
	// sample stream out
	output logic [ddc_capture_pkg::NumBuses-1:0] sampleValid,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] sampleReady,
	output logic [ddc_capture_pkg::NumBuses*Width-1:0] sampleData,
	// status
	output logic [ddc_capture_pkg::NumBuses-1:0] overflow,
	output logic halted,
	output logic [ddc_capture_pkg::NumBuses-1:0] bitReverse
);
	// elaboration check: order reversal and fifo are sized for up to 32 bits
	if (Width < 1 || Width > 32)
	begin : g_bad_width
		$error("sample width out of range");
	end

	// bit reversal, used on every bus
	function automatic logic [Width-1:0] revBits(input logic [Width-1:0] v);
		logic [Width-1:0] r;
		r = '0;
		for (int i = 0; i < Width; i++)
			r[i] = v[Width-1-i];
		return r;
	endfunction

	// two-flop synchronisers for reset pin and sync inputs
	logic [2:0] ctlMeta_q;
	logic [2:0] ctlSync_q;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			// idle pin levels: reset pin released, syncs low, so no false rise after reset
			ctlMeta_q <= 3'h4;
			ctlSync_q <= 3'h4;
		end
		else
		begin
			ctlMeta_q <= {resetPin_n, global_sync_in_2, global_sync_in_1};
			ctlSync_q <= ctlMeta_q;
		end
	end
	wire resetPinSync_n = ctlSync_q[2];
	wire sync2Lvl = ctlSync_q[1];
	wire sync1Lvl = ctlSync_q[0];

	wire haltNow = !resetPinSync_n;

	// configuration held in indirect location zero, defaults on reset pin
	logic [NumBuses-1:0] bitReverse_q;
	wire cfgWrite = indirectWrite && (indirectWordAddr == IndirectLocZero);
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			bitReverse_q <= '0;
		else if (haltNow)
			bitReverse_q <= '0;
		else if (cfgWrite)
			bitReverse_q <= {NumBuses{indirectWordData[BitReversePos]}};
	end
	assign bitReverse = bitReverse_q;

	// sync output pulse generation
	logic prevSoft_q;
	logic prevS1_q;
	logic prevS2_q;
	logic [1:0] pulseCnt_q;
	logic syncOut_q;
	wire softRise = softSync && !prevSoft_q;
	wire s1Rise = sync1Lvl && !prevS1_q;
	wire s2Rise = sync2Lvl && !prevS2_q;
	wire outTrig = (syncOutSrc == SyncSrcSoft) ? softRise :
		(syncOutSrc == SyncSrcIn1) ? s1Rise :
		(syncOutSrc == SyncSrcIn2) ? s2Rise : 1'b0;
	// sync output pulse stretcher
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prevSoft_q <= 1'b0;
			pulseCnt_q <= '0;
			syncOut_q <= 1'b0;
		end
		else
		begin
			prevSoft_q <= softSync;
			if (outTrig && !haltNow)
				pulseCnt_q <= 2'(SyncPulseCycles);
			else if (pulseCnt_q != '0)
				pulseCnt_q <= pulseCnt_q - 2'h1;
			syncOut_q <= (outTrig && !haltNow) || (pulseCnt_q > 2'h1);
		end
	end
	assign sync_output = syncOut_q;

	wire eff1 = sync1Lvl || ((loopSel == LoopIn1) && syncOut_q);
	wire eff2 = sync2Lvl || ((loopSel == LoopIn2) && syncOut_q);
	logic prevE1_q;
	logic prevE2_q;
	wire e1Rise = eff1 && !prevE1_q;
	wire e2Rise = eff2 && !prevE2_q;
	wire [NumTargets-1:0] actNext = ({NumTargets{e1Rise}} & syncRespEn1) |
		({NumTargets{e2Rise}} & syncRespEn2);
	logic [NumTargets-1:0] syncAction_q;
	// sync edge and action registers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prevS1_q <= 1'b0;
			prevS2_q <= 1'b0;
			prevE1_q <= 1'b0;
			prevE2_q <= 1'b0;
			syncAction_q <= '0;
		end
		else
		begin
			prevS1_q <= sync1Lvl;
			prevS2_q <= sync2Lvl;
			prevE1_q <= eff1;
			prevE2_q <= eff2;
			syncAction_q <= haltNow ? '0 : actNext;
		end
	end
	assign syncAction = syncAction_q;

	// halted status flop
	logic halted_q;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			halted_q <= 1'b1;
		else
			halted_q <= haltNow;
	end
	assign halted = halted_q;

	// all bus clocks synchronised once; the bus C copy is shared as master
	logic [NumBuses-1:0] clkMeta_q;
	logic [NumBuses-1:0] clkSync_q;
	logic [NumBuses-1:0] clkPrev_q;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			clkMeta_q <= '0;
			clkSync_q <= '0;
			clkPrev_q <= '0;
		end
		else
		begin
			clkMeta_q <= busClk;
			clkSync_q <= clkMeta_q;
			clkPrev_q <= clkSync_q;
		end
	end

	// per-bus capture lanes
	// per-lane results gathered as nets, one slice per lane
	wire [NumBuses-1:0] laneOvf;
	wire [NumBuses-1:0] laneValid;
	wire [NumBuses*Width-1:0] laneData;
	genvar b;
	generate
		for (b = 0; b < NumBuses; b++)
		begin : g_bus
			// data and enable synchronisers; the source holds them across the edge
			logic [Width-1:0] dMeta_q;
			logic [Width-1:0] dSync_q;
			logic enMeta_q;
			logic enSync_q;
			logic [Width-1:0] held_q;
			logic pushValid_q;
			logic [Width-1:0] pushData_q;
			cap_state_e state_q;
			wire pushReady;
			logic ovf_q;
			logic fifoValid;
			logic [Width-1:0] fifoData;
			logic outValid_q;
			logic [Width-1:0] outData_q;
			// the slice takes a word when empty or when its own word leaves this cycle
			wire sliceRoom = !outValid_q || sampleReady[b];
			wire sliceTake = fifoValid && sliceRoom;
			// clock select, bus C always master
			wire selClk = (b == BusC || useMasterClk[b]) ? clkSync_q[BusC] : clkSync_q[b];
			wire selPrev = (b == BusC || useMasterClk[b]) ? clkPrev_q[BusC] : clkPrev_q[b];
			wire capEdge = edgeFalling[b] ? (selPrev && !selClk) : (!selPrev && selClk);
			wire enAct = !enSync_q;
			wire [Width-1:0] rawIn = busData[b*Width +: Width];
			wire [Width-1:0] ordered = bitReverse_q[b] ? revBits(dSync_q) : dSync_q;
			// interpolated mode repeats last sample while disabled
			wire takeNew = capEdge && enAct;
			wire takeRep = capEdge && !enAct && interpMode[b];
			wire running = (state_q == CapArmed);
			// input synchronisers
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					dMeta_q <= '0;
					dSync_q <= '0;
					enMeta_q <= 1'b1;
					enSync_q <= 1'b1;
				end
				else
				begin
					dMeta_q <= rawIn;
					dSync_q <= dMeta_q;
					enMeta_q <= bus_enable_n[b];
					enSync_q <= enMeta_q;
				end
			end
			// lane state: halted while the reset pin is low
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
					state_q <= CapHalted;
				else
				begin
					unique case (state_q)
						CapHalted: state_q <= haltNow ? CapHalted : CapIdle;
						CapIdle: state_q <= haltNow ? CapHalted : CapArmed;
						CapArmed: state_q <= haltNow ? CapHalted : CapArmed;
						default: state_q <= CapHalted;
					endcase
				end
			end
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					pushValid_q <= 1'b0;
					pushData_q <= '0;
					held_q <= '0;
				end
				else
				begin
					pushValid_q <= running && (takeNew || takeRep);
					if (takeNew)
						held_q <= ordered;
					pushData_q <= takeNew ? ordered : held_q;
				end
			end
			// sticky overflow, set wins over halt clear
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
					ovf_q <= 1'b0;
				else if (pushValid_q && !pushReady)
					ovf_q <= 1'b1;
				else if (haltNow)
					ovf_q <= 1'b0;
			end
			capture_fifo #(.Width(Width), .Depth(Depth)) u_fifo
			(
				.clk(clk),
				.sys_rst(sys_rst),
				.inValid(pushValid_q),
				.inReady(pushReady),
				.inData(pushData_q),
				.outValid(fifoValid),
				.outReady(sliceRoom),
				.outData(fifoData)
			);
			// output slice keeps the stream ports on flops; it costs one cycle
			// and holds one word beyond the fifo depth
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					outValid_q <= 1'b0;
					outData_q <= '0;
				end
				else
				begin
					// a stalled word stays put, otherwise the next fifo word moves up
					outValid_q <= fifoValid || (outValid_q && !sampleReady[b]);
					if (sliceTake)
						outData_q <= fifoData;
				end
			end
			assign laneOvf[b] = ovf_q;
			assign laneValid[b] = outValid_q;
			assign laneData[b*Width +: Width] = outData_q;
		end
	endgenerate
	assign overflow = laneOvf;
	assign sampleValid = laneValid;
	assign sampleData = laneData;
endmodule

// >>> verif/ddc_capture_monitor.sv
// Purpose: port checker for the capture front end
// Assumes: bound to the top module, one clock domain
// Notes: bus 0 stands for the four identical lanes
`timescale 1ns/1ns
module ddc_capture_monitor
	import ddc_capture_pkg::*;
#(
	parameter int Width = 17
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// watched pins
	input wire logic resetPin_n,
	input wire logic indirectWrite,
	input wire logic [15:0] indirectWordAddr,
	input wire logic [15:0] indirectWordData,
	input wire logic [ddc_capture_pkg::NumTargets-1:0] syncRespEn1,
	input wire logic [ddc_capture_pkg::NumTargets-1:0] syncRespEn2,
	input wire logic [ddc_capture_pkg::NumTargets-1:0] syncAction,
	input wire logic sync_output,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] sampleValid,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] sampleReady,
	input wire logic [ddc_capture_pkg::NumBuses*Width-1:0] sampleData,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] overflow,
	input wire logic halted,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] bitReverse
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// pulse shape and pin low long enough to pass the synchroniser
	sequence pulseTwo; sync_output ##1 !sync_output; endsequence
	sequence pinLow; !resetPin_n [*4]; endsequence
	AST_SYNC_OUT_LEN: assert property ($rose(sync_output) |=> pulseTwo)
		else $error("sync output pulse not two cycles");
	AST_ACT_PULSE: assert property (syncAction != 0 |=> syncAction == 0)
		else $error("sync action longer than one cycle");
	AST_ACT_EN: assert property (syncAction != 0
		|-> (syncAction & ~($past(syncRespEn1) | $past(syncRespEn2))) == 0)
		else $error("sync action on a disabled target");
	AST_HALT: assert property (pinLow |-> halted)
		else $error("not halted under reset pin");
	AST_HALT_CLR: assert property (pinLow |-> bitReverse == 0 && overflow == 0)
		else $error("flags kept under reset pin");
	AST_REV_SET: assert property (indirectWrite && indirectWordAddr == IndirectLocZero
		&& !halted && $past(resetPin_n, 2)
		|=> bitReverse == {NumBuses{$past(indirectWordData[BitReversePos])}})
		else $error("order flag not taken from location zero");
	AST_REV_KEEP: assert property (indirectWrite && indirectWordAddr != IndirectLocZero
		&& $past(resetPin_n, 2)
		|=> $stable(bitReverse))
		else $error("order flag moved by another location");
	AST_HOLD: assert property (sampleValid[0] && !sampleReady[0]
		|=> sampleValid[0] && $stable(sampleData[Width-1:0]))
		else $error("sample dropped while stalled");
	AST_OVF_STICK: assert property (overflow[0] && $past(resetPin_n) |=> overflow[0])
		else $error("overflow flag not sticky");
endmodule
bind ddc_input_capture_sync ddc_capture_monitor #(.Width(Width)) ddc_capture_monitor_i (.clk,
	.sys_rst, .resetPin_n, .indirectWrite, .indirectWordAddr, .indirectWordData, .syncRespEn1,
	.syncRespEn2, .syncAction, .sync_output, .sampleValid, .sampleReady, .sampleData, .overflow,
	.halted, .bitReverse);

// >>> verif/sample_source.sv
// Purpose: source model for the four sample buses
// Assumes: bus clocks of 800 ns, unrelated to clk
// Notes: disabled words show inverted data, never a stale copy
`timescale 1ns/1ns
module sample_source
	import ddc_capture_pkg::*;
(
	// lane setup
	input wire logic run,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] gateOn,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] edgeFalling,
	input wire logic [ddc_capture_pkg::NumBuses-1:0] useMasterClk,
	// bus pins
	output logic [ddc_capture_pkg::NumBuses-1:0] busClk,
	output logic [ddc_capture_pkg::NumBuses-1:0] bus_enable_n,
	output logic [ddc_capture_pkg::NumBuses*ddc_capture_pkg::SampleWidth-1:0] busData
);
	int cnt [4] = '{0, 4099, 8198, 12297}; // per-lane word counter
	logic [3:0] lastClk = '0; // previous clock levels
	logic [SampleWidth-1:0] w; // word being replaced
	int s; // clock serving the lane
	// clocks with staggered phase offsets; they stand still while run is low
	initial
	begin
		busClk = '0;
		bus_enable_n = '1;
		busData = '0;
		for (int b = 0; b < NumBuses; b++)
			fork
				automatic int k = b;
				begin
					#(k * 137 + 29);
					forever
					begin
						#400;
						if (run)
							busClk[k] = ~busClk[k];
					end
				end
			join_none
	end
	always @(busClk)
	begin
		for (int k = 0; k < NumBuses; k++)
		begin
			s = (useMasterClk[k] && k != BusC) ? BusC : k;
			if (busClk[s] !== lastClk[s] && busClk[s] === edgeFalling[k])
			begin
				cnt[k]++;
				w = busData[k*SampleWidth+:SampleWidth];
				// enable low always when gated on, else every other word
				bus_enable_n[k] = !(gateOn[k] || cnt[k][0]);
				busData[k*SampleWidth+:SampleWidth] = bus_enable_n[k] ? ~w : w ^ SampleWidth'(cnt[k] * 77);
			end
		end
		lastClk = busClk;
	end
endmodule

// >>> verif/ddc_input_capture_sync_tb_top.sv
// Purpose: self-checking bench for the capture front end
// Assumes: source model on the bus pins, bench drains the stream
// Notes: reference queues fill at the pin edges, ahead of the design
`timescale 1ns/1ns
module ddc_input_capture_sync_tb_top;
	import ddc_capture_pkg::*;
	logic clk = 0, sys_rst = 1, resetPin_n = 1, run = 0, indirectWrite = 0;
	logic global_sync_in_1 = 0, global_sync_in_2 = 0, softSync = 0, sync_output, halted;
	logic [3:0] edgeFalling = 0, useMasterClk = 0, interpMode = 0, gateOn = 0, sampleReady = 0;
	logic [3:0] syncRespEn1 = 0, syncRespEn2 = 0, syncAction, sampleValid, overflow, bitReverse;
	logic [3:0] busClk, bus_enable_n, lastClk = 0, revExp = 0, ovfExp = 0, act;
	logic [1:0] syncOutSrc = 0, loopSel = 0;
	logic [15:0] indirectWordAddr = 0, indirectWordData = 0;
	logic [4*SampleWidth-1:0] busData, sampleData;
	logic [SampleWidth-1:0] q [4][$], last [4], w; // reference queues
	logic [31:0] seed = 32'h31A5F37B;
	int error_cnt = 0, cmp_count = 0, drain = 0, s, seen;
	ddc_input_capture_sync ddc_input_capture_sync_i (.clk, .sys_rst, .resetPin_n, .busData,
		.bus_enable_n, .busClk, .edgeFalling, .useMasterClk, .interpMode, .indirectWordAddr,
		.indirectWordData, .indirectWrite, .global_sync_in_1, .global_sync_in_2, .syncRespEn1,
		.syncRespEn2, .syncOutSrc, .softSync, .loopSel, .syncAction, .sync_output, .sampleValid,
		.sampleReady, .sampleData, .overflow, .halted, .bitReverse);
	sample_source sample_source_i (.run, .gateOn, .edgeFalling, .useMasterClk, .busClk,
		.bus_enable_n, .busData);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int qsum();
		return q[0].size() + q[1].size() + q[2].size() + q[3].size();
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("mismatches %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// lane setup changes only while halted, so no false edge reaches a lane
	task automatic halt_check(input logic [7:0] cfg, input logic [3:0] im);
		@(negedge clk);
		resetPin_n = 0;
		repeat (6) @(negedge clk);
		check({halted, bitReverse, overflow}, 9'h100);
		{revExp, ovfExp, interpMode} = {8'h00, im};
		{edgeFalling, useMasterClk} = cfg;
		resetPin_n = 1;
		repeat (4) @(negedge clk);
	endtask
	task automatic wr_loc(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		{indirectWordAddr, indirectWordData, indirectWrite} = {a, d, 1'b1};
		@(negedge clk);
		indirectWrite = 0;
		if (a == IndirectLocZero)
			revExp = {NumBuses{d[BitReversePos]}};
		@(negedge clk);
		check(bitReverse, revExp);
	endtask
	initial
	begin
		forever #50 clk = ~clk;
	end
	// reference capture at the selected pin edge; interpolated lanes repeat
	always @(busClk)
	begin
		for (int k = 0; k < 4; k++)
		begin
			s = (useMasterClk[k] && k != BusC) ? BusC : k;
			w = busData[k*SampleWidth+:SampleWidth];
			if (busClk[s] !== lastClk[s] && busClk[s] !== edgeFalling[k])
				if (!bus_enable_n[k] || interpMode[k])
				begin
					if (!bus_enable_n[k] && revExp[k])
						last[k] = {<<{w}};
					else if (!bus_enable_n[k])
						last[k] = w;
					// the output slice holds one word beyond the fifo
					if (q[k].size() < FifoDepth + 1)
						q[k].push_back(last[k]);
					else
						ovfExp[k] = 1;
				end
		end
		lastClk = busClk;
	end
	// random drain stalls, launched off the sampling edge
	always @(negedge clk)
		sampleReady <= drain == 2 ? 4'hF : drain == 1 ? 4'(xs()) : 4'h0;
	always @(posedge clk)
		for (int k = 0; k < 4; k++)
			if (sampleValid[k] === 1'b1 && sampleReady[k] === 1'b1)
				check(sampleData[k*SampleWidth+:SampleWidth], q[k].size() ? q[k].pop_front() : '1);
	initial
	begin
		#5000000;
		error_cnt++;
		test_done();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		sys_rst = 0;
		// phases: plain, reversed, other location, interpolated, overflow
		for (int p = 0; p < 5; p++)
		begin
			halt_check(8'(xs()), p == 3 ? 4'hF : 4'h0);
			if (p > 0 && p < 4)
				wr_loc(p == 2 ? 16'h0001 : 16'h0000, p == 2 ? 16'hFFFF : 16'h0010);
			gateOn = 4'hF;
			drain = p == 4 ? 0 : 1;
			run = 1'b1;
			repeat (200) @(negedge clk);
			gateOn = p == 3 ? 4'h0 : p == 4 ? 4'hF : 4'(xs());
			repeat (p == 4 ? 200 : 1400) @(negedge clk);
			run = 0;
			repeat (8) @(negedge clk);
			check(overflow, ovfExp);
			drain = 2;
			for (int i = 0; i < 300 && qsum() > 0; i++)
				@(negedge clk);
			check(qsum(), 0);
		end
		halt_check(8'h00, 4'h0);
		// triggers 0-2 against every output source; trigger 3 is loopback on the soft source only
		for (int t = 0; t < 4; t++)
			for (int src = 0; src < 4; src++)
			begin
				{syncRespEn1, syncRespEn2} = 8'(xs());
				{syncOutSrc, loopSel, act} = {t == 3 ? 2'h0 : 2'(src), t == 3 ? 2'h1 : 2'h0, 4'h0};
				seen = 0;
				{softSync, global_sync_in_1, global_sync_in_2} = t == 1 ? 3'h2 : t == 2 ? 3'h1 : 3'h4;
				repeat (12)
				begin
					@(negedge clk);
					act |= syncAction;
					seen |= sync_output;
				end
				@(negedge clk);
				{softSync, global_sync_in_1, global_sync_in_2} = 3'h0;
				repeat (6) @(negedge clk);
				check(act, t == 1 || t == 3 ? syncRespEn1 : t == 2 ? syncRespEn2 : 4'h0);
				check(seen, t == 3 || src == t);
			end
		test_done();
	end
endmodule
